// file: common/sxio_map.svh
// register offsets, field positions, reset values and timing counts of the io port
`ifndef SXIO_MAP_SVH
`define SXIO_MAP_SVH

`define SXIO_ADDR_W 8
`define SXIO_OFF_MODE 8'h00
`define SXIO_OFF_DRIVE 8'h04
`define SXIO_OFF_SPEED 8'h08
`define SXIO_OFF_PULL 8'h0C
`define SXIO_OFF_INSTAT 8'h10
`define SXIO_OFF_OUTLEV 8'h14
`define SXIO_OFF_SET 8'h18
`define SXIO_OFF_FREEZE 8'h1C
`define SXIO_OFF_AFSEL0 8'h20
`define SXIO_OFF_AFSEL1 8'h24
`define SXIO_OFF_CLEAR 8'h28
`define SXIO_OFF_TOGGLE 8'h2C

`define SXIO_RST_MODE_A 32'h2800_0000
`define SXIO_RST_SPEED_A 32'h0C00_0000
`define SXIO_RST_PULL_A 32'h2400_0000
`define SXIO_RST_ZERO 32'h0000_0000

`define SXIO_FREEZE_KEY_BIT 16
`define SXIO_SYNC_STAGES 3

`endif

// file: common/sxio_pkg.sv
// types shared by the io port design
`default_nettype none
package sxio_pkg;

	// per-pin mode codes
	typedef enum logic [1:0] {
		SXIO_MODE_INPUT = 2'h0,
		SXIO_MODE_OUTPUT = 2'h1,
		SXIO_MODE_ALT = 2'h2,
		SXIO_MODE_ANALOG = 2'h3
	} sxio_mode_t;

	// freeze key sequence states, gray along the path
	typedef enum logic [1:0] {
		SXIO_FRZ_IDLE = 2'h0,
		SXIO_FRZ_ONE = 2'h1,
		SXIO_FRZ_ZERO = 2'h3
	} sxio_frz_t;

	// register port request
	typedef struct packed {
		logic sel;
		logic wr;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} sxio_req_t;

	// additional function override per pin group
	typedef struct packed {
		logic [15:0] en;
		logic [15:0] dout;
		logic [15:0] oe;
	} sxio_addfn_t;

endpackage

`default_nettype wire

// file: rtl/sxio_port.sv
// sixteen pin general purpose io port with register port and pad drive
// Contract
// - two-bit mode per pin: 00 input, 01 output, 10 alternate, 11 analog
// - mode fields packed two bits per pin, pin 15 at top, read and write
// - mode register resets to 0x28000000 on port A, zero elsewhere
// - after reset alternate functions idle, pins floating inputs without pulls, except port A debug pins 13 and 14
// - after reset debug clock pin alt with pull-down, data pin alt with pull-up
// - pads sampled into input status every clock in digital modes
// - input mode: output buffer off, receiver on, pull selectable
// - output mode drives pin from output level register bit
// - open-drain: bit 0 pulls low, bit 1 releases pad
// - push-pull: bit 0 drives low, bit 1 drives high
// - output level reads last written, input status reads pad state
// - set, clear, toggle writes change only bits written as one
// - toggle write inverts the output level within one cycle
// - analog mode: pulls, buffer, receiver off, input status reads zero
// - alternate mode: peripheral drives and steers pin, drive and pull still apply
// - alternate mode reads: pad state in status, last written in output level
// - each pin picks one of sixteen alternate functions via two select registers
// - additional functions override the pin setup and release it when off
// - freeze sequence locks a pin's configuration until next reset
// - drive type bit per pin, reset 0: 0 push-pull, 1 open-drain
// - two-bit pull field: 00 floating, 01 up, 10 down, 11 reserved
// - two-bit speed field: x0 lowest, 01 middle, 11 highest
`timescale 1ns/1ps
`default_nettype none
`include "sxio_map.svh"

module sxio_port #(
	parameter bit IS_PORT_A = 1'b1,
	parameter int PINS = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire sxio_pkg::sxio_req_t req,
	output logic [31:0] rdata,
	output logic rvalid,
	input wire logic [PINS-1:0] pad_in,
	output logic [PINS-1:0] pad_out,
	output logic [PINS-1:0] pad_oe_n,
	output logic [PINS-1:0] pull_up_en,
	output logic [PINS-1:0] pull_dn_en,
	output logic [PINS-1:0] rx_en,
	output logic [2*PINS-1:0] speed_sel,
	output logic [4*PINS-1:0] alt_sel,
	input wire logic [PINS-1:0] alt_dout,
	input wire logic [PINS-1:0] alt_oe,
	output logic [PINS-1:0] alt_din,
	input wire sxio_pkg::sxio_addfn_t addfn
);

	// spread one bit per pin over two-bit fields
	function automatic logic [31:0] exp2(input logic [15:0] m);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int i = 0; i < 16; i++) begin
			r[2*i +: 2] = {2{m[i]}};
		end
		return r;
	endfunction

	// spread one bit per pin over four-bit fields
	function automatic logic [63:0] exp4(input logic [15:0] m);
		logic [63:0] r;
		r = 64'h0000_0000_0000_0000;
		for (int i = 0; i < 16; i++) begin
			r[4*i +: 4] = {4{m[i]}};
		end
		return r;
	endfunction

	// byte-lane write merge, frozen bits kept
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] keep);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return (r & ~keep) | (old & keep);
	endfunction

	// pins whose two-bit field equals a code
	function automatic logic [15:0] is_mode(input logic [31:0] f, input logic [1:0] code);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[i] = (f[2*i +: 2] == code);
		end
		return r;
	endfunction

	localparam logic [31:0] RST_MODE = IS_PORT_A ? `SXIO_RST_MODE_A : `SXIO_RST_ZERO;
	localparam logic [31:0] RST_SPEED = IS_PORT_A ? `SXIO_RST_SPEED_A : `SXIO_RST_ZERO;
	localparam logic [31:0] RST_PULL = IS_PORT_A ? `SXIO_RST_PULL_A : `SXIO_RST_ZERO;

	logic [31:0] mode_q;
	logic [15:0] drive_q;
	logic [31:0] speed_q;
	logic [31:0] pull_q;
	logic [15:0] outlev_q;
	logic [63:0] afsel_q;
	logic [15:0] frz_q;
	logic frz_key_q;
	sxio_pkg::sxio_frz_t frz_st_q;
	logic [15:0] frz_mask_q;
	logic [15:0] sync1_q, sync2_q, sync3_q, pad_q;
	logic [15:0] instat_q;
	logic [31:0] rdata_q;
	logic rvalid_q;
	logic wr_en, rd_en;
	logic [31:0] wd;
	logic [15:0] m_out, m_alt, m_ana, m_in;
	logic [15:0] drv_val, drv_en, add_on;
	logic [31:0] drive_w, outlev_w;
	logic [63:0] afsel_keep;

	assign wr_en = req.sel & req.wr;
	assign rd_en = req.sel & ~req.wr;
	assign wd = req.wdata;
	assign drive_w = wmerge({16'h0000, drive_q}, wd, req.be, {16'hFFFF, frz_q});
	assign outlev_w = wmerge({16'h0000, outlev_q}, wd, req.be, 32'h0000_0000);
	assign afsel_keep = exp4(frz_q);

	// mode register, frozen pins keep their field
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_q <= RST_MODE;
		end else if (wr_en && req.addr == `SXIO_OFF_MODE) begin
			mode_q <= wmerge(mode_q, wd, req.be, exp2(frz_q));
		end
	end

	// drive type bits, low half only
	always_ff @(posedge clk) begin
		if (reset) begin
			drive_q <= 16'h0000;
		end else if (wr_en && req.addr == `SXIO_OFF_DRIVE) begin
			drive_q <= drive_w[15:0];
		end
	end

	// speed fields
	always_ff @(posedge clk) begin
		if (reset) begin
			speed_q <= RST_SPEED;
		end else if (wr_en && req.addr == `SXIO_OFF_SPEED) begin
			speed_q <= wmerge(speed_q, wd, req.be, exp2(frz_q));
		end
	end

	// pull fields
	always_ff @(posedge clk) begin
		if (reset) begin
			pull_q <= RST_PULL;
		end else if (wr_en && req.addr == `SXIO_OFF_PULL) begin
			pull_q <= wmerge(pull_q, wd, req.be, exp2(frz_q));
		end
	end

	// alternate function selects, four bits per pin over two words
	always_ff @(posedge clk) begin
		if (reset) begin
			afsel_q <= 64'h0000_0000_0000_0000;
		end else if (wr_en && req.addr == `SXIO_OFF_AFSEL0) begin
			afsel_q[31:0] <= wmerge(afsel_q[31:0], wd, req.be, afsel_keep[31:0]);
		end else if (wr_en && req.addr == `SXIO_OFF_AFSEL1) begin
			afsel_q[63:32] <= wmerge(afsel_q[63:32], wd, req.be, afsel_keep[63:32]);
		end
	end

	// output level: direct write, set/clear word, clear word, toggle word
	always_ff @(posedge clk) begin
		if (reset) begin
			outlev_q <= 16'h0000;
		end else if (wr_en) begin
			case (req.addr)
				`SXIO_OFF_OUTLEV: begin
					outlev_q <= outlev_w[15:0];
				end
				`SXIO_OFF_SET: begin
					outlev_q <= (outlev_q & ~wd[31:16]) | wd[15:0];
				end
				`SXIO_OFF_CLEAR: begin
					outlev_q <= outlev_q & ~wd[15:0];
				end
				`SXIO_OFF_TOGGLE: begin
					outlev_q <= outlev_q ^ wd[15:0];
				end
				default: begin
					outlev_q <= outlev_q;
				end
			endcase
		end
	end

	// freeze key: write key 1, key 0, key 1 with the same mask
	always_ff @(posedge clk) begin
		if (reset) begin
			frz_st_q <= sxio_pkg::SXIO_FRZ_IDLE;
			frz_mask_q <= 16'h0000;
			frz_q <= 16'h0000;
			frz_key_q <= 1'b0;
		end else if (wr_en && req.addr == `SXIO_OFF_FREEZE && req.be == 4'hF) begin
			case (frz_st_q)
				sxio_pkg::SXIO_FRZ_IDLE: begin
					if (wd[`SXIO_FREEZE_KEY_BIT]) begin
						frz_st_q <= sxio_pkg::SXIO_FRZ_ONE;
						frz_mask_q <= wd[15:0];
					end
				end
				sxio_pkg::SXIO_FRZ_ONE: begin
					if (!wd[`SXIO_FREEZE_KEY_BIT] && wd[15:0] == frz_mask_q) begin
						frz_st_q <= sxio_pkg::SXIO_FRZ_ZERO;
					end else begin
						frz_st_q <= sxio_pkg::SXIO_FRZ_IDLE;
					end
				end
				sxio_pkg::SXIO_FRZ_ZERO: begin
					frz_st_q <= sxio_pkg::SXIO_FRZ_IDLE;
					if (wd[`SXIO_FREEZE_KEY_BIT] && wd[15:0] == frz_mask_q) begin
						frz_q <= frz_q | frz_mask_q;
						frz_key_q <= 1'b1;
					end
				end
				default: begin
					frz_st_q <= sxio_pkg::SXIO_FRZ_IDLE;
				end
			endcase
		end
	end

	// pad synchroniser, change accepted once stages two and three agree
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_q <= 16'h0000;
			sync2_q <= 16'h0000;
			sync3_q <= 16'h0000;
			pad_q <= 16'h0000;
		end else begin
			sync1_q <= pad_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pad_q <= (pad_q & ~(sync2_q ^ sync3_q)) | (sync3_q & ~(sync2_q ^ sync3_q));
		end
	end

	// mode decode, additional functions override
	assign add_on = addfn.en;
	assign m_in = is_mode(mode_q, sxio_pkg::SXIO_MODE_INPUT) & ~add_on;
	assign m_out = is_mode(mode_q, sxio_pkg::SXIO_MODE_OUTPUT) & ~add_on;
	assign m_alt = is_mode(mode_q, sxio_pkg::SXIO_MODE_ALT) & ~add_on;
	assign m_ana = is_mode(mode_q, sxio_pkg::SXIO_MODE_ANALOG) & ~add_on;

	// input status sampled every cycle, analog pins read zero
	always_ff @(posedge clk) begin
		if (reset) begin
			instat_q <= 16'h0000;
		end else begin
			instat_q <= pad_q & ~m_ana;
		end
	end

	// drive source: output level, peripheral or additional function
	assign drv_val = (m_out & outlev_q) | (m_alt & alt_dout) | (add_on & addfn.dout);
	assign drv_en = m_out | (m_alt & alt_oe) | (add_on & addfn.oe);

	// push-pull drives both levels, open-drain only pulls low
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (drive_q[i] && !add_on[i]) begin
				pad_out[i] = 1'b0;
				pad_oe_n[i] = ~(drv_en[i] & ~drv_val[i]);
			end else begin
				pad_out[i] = drv_val[i];
				pad_oe_n[i] = ~drv_en[i];
			end
		end
	end

	// pulls off for analog and additional functions, receiver off for analog only
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			pull_up_en[i] = ~m_ana[i] & ~add_on[i] & (pull_q[2*i +: 2] == 2'h1);
			pull_dn_en[i] = ~m_ana[i] & ~add_on[i] & (pull_q[2*i +: 2] == 2'h2);
		end
	end

	assign rx_en = m_in | m_out | m_alt | add_on;
	assign speed_sel = speed_q;
	assign alt_sel = afsel_q;
	assign alt_din = instat_q & m_alt;

	// registered read data, unmapped and write-only offsets read zero
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= rd_en;
			if (rd_en) begin
				case (req.addr)
					`SXIO_OFF_MODE: rdata_q <= mode_q;
					`SXIO_OFF_DRIVE: rdata_q <= {16'h0000, drive_q};
					`SXIO_OFF_SPEED: rdata_q <= speed_q;
					`SXIO_OFF_PULL: rdata_q <= pull_q;
					`SXIO_OFF_INSTAT: rdata_q <= {16'h0000, instat_q};
					`SXIO_OFF_OUTLEV: rdata_q <= {16'h0000, outlev_q};
					`SXIO_OFF_FREEZE: rdata_q <= {15'h0, frz_key_q, frz_q};
					`SXIO_OFF_AFSEL0: rdata_q <= afsel_q[31:0];
					`SXIO_OFF_AFSEL1: rdata_q <= afsel_q[63:32];
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign rdata = rdata_q;
	assign rvalid = rvalid_q;

	a_mode_reset: assert property (@(posedge clk) reset |=> mode_q == RST_MODE)
		else $error("mode register reset value wrong");

	a_pull_reset: assert property (@(posedge clk) reset |=> pull_q == RST_PULL && drive_q == 16'h0000)
		else $error("pull or drive reset value wrong");

	a_analog_zero: assert property (@(posedge clk) disable iff (reset)
		1 |=> (instat_q & $past(m_ana)) == 16'h0000)
		else $error("analog pin reads nonzero status");

	a_analog_off: assert property (@(posedge clk) disable iff (reset)
		((pull_up_en | pull_dn_en | rx_en | ~pad_oe_n) & m_ana) == 16'h0000)
		else $error("analog pin not isolated");

	a_pp_drive: assert property (@(posedge clk) disable iff (reset)
		(((pad_out ^ outlev_q) | pad_oe_n) & m_out & ~drive_q) == 16'h0000)
		else $error("push-pull pin not following output level");

	a_od_release: assert property (@(posedge clk) disable iff (reset)
		((pad_oe_n ^ outlev_q) & m_out & drive_q) == 16'h0000)
		else $error("open-drain pin drive wrong");

	a_input_hiz: assert property (@(posedge clk) disable iff (reset)
		(~pad_oe_n & m_in) == 16'h0000)
		else $error("input pin drives pad");

	a_toggle_flip: assert property (@(posedge clk) disable iff (reset)
		wr_en && req.addr == `SXIO_OFF_TOGGLE |=> outlev_q == ($past(outlev_q) ^ $past(wd[15:0])))
		else $error("toggle write did not invert level");

	a_set_wins: assert property (@(posedge clk) disable iff (reset)
		wr_en && req.addr == `SXIO_OFF_SET |=> (outlev_q & $past(wd[15:0])) == $past(wd[15:0])
		&& (outlev_q & $past(wd[31:16] & ~wd[15:0])) == 16'h0000)
		else $error("set or clear write wrong");

	a_frozen_mode: assert property (@(posedge clk) disable iff (reset)
		1 |=> ((mode_q ^ $past(mode_q)) & exp2($past(frz_q))) == 32'h0000_0000)
		else $error("frozen mode field changed");

	a_freeze_order: assert property (@(posedge clk) disable iff (reset)
		frz_st_q != sxio_pkg::SXIO_FRZ_ZERO |=> frz_q == $past(frz_q))
		else $error("freeze took effect out of order");

endmodule // sxio_port

`default_nettype wire

// file: tb/sxio_pad_model.sv
// behavioural model of the pads and the board around the io port
`timescale 1ns/1ps
`default_nettype none

module sxio_pad_model (
	input wire logic clk,
	input wire logic [15:0] pad_out,
	input wire logic [15:0] pad_oe_n,
	input wire logic [15:0] pull_up_en,
	input wire logic [15:0] pull_dn_en,
	input wire logic [15:0] ext_en,
	input wire logic [15:0] ext_val,
	output logic [15:0] pad_in
);
	logic [15:0] float_q = 16'h5555;

	// an undriven pad with no pull wanders every cycle
	always @(posedge clk) begin
		float_q <= ~float_q;
	end

	// pad level: port drive, else board drive, else pull, else wander
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pad_oe_n[i] == 1'b0)
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pull_up_en[i])
				pad_in[i] = 1'b1;
			else if (pull_dn_en[i])
				pad_in[i] = 1'b0;
			else
				pad_in[i] = float_q[i];
		end
	end
endmodule // sxio_pad_model

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the sixteen pin io port
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	sxio_pkg::sxio_req_t req;
	sxio_pkg::sxio_addfn_t addfn;
	logic [31:0] rdata;
	logic rvalid;
	logic [15:0] pad_in, pad_out, pad_oe_n, pull_up_en, pull_dn_en, rx_en;
	logic [15:0] alt_dout, alt_oe, alt_din, ext_en, ext_val;
	logic [31:0] speed_sel;
	logic [63:0] alt_sel;
	logic [31:0] expq[$];
	logic [31:0] r, r2;
	logic [3:0] dr;
	logic [31:0] rdata_b;
	logic [15:0] pull_up_en_b;
	int n_mismatch = 0;
	int comparisons = 0;

	always #10 clk = ~clk;

	sxio_port #(.IS_PORT_A(1'b1), .PINS(16)) dut (.clk(clk), .reset(reset), .req(req),
		.rdata(rdata), .rvalid(rvalid), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
		.rx_en(rx_en), .speed_sel(speed_sel), .alt_sel(alt_sel), .alt_dout(alt_dout),
		.alt_oe(alt_oe), .alt_din(alt_din), .addfn(addfn));

	// second port with the plain reset values
	sxio_port #(.IS_PORT_A(1'b0), .PINS(16)) dut_b (.clk(clk), .reset(reset), .req(req),
		.rdata(rdata_b), .rvalid(), .pad_in(pad_in), .pad_out(), .pad_oe_n(),
		.pull_up_en(pull_up_en_b), .pull_dn_en(), .rx_en(), .speed_sel(), .alt_sel(),
		.alt_dout(alt_dout), .alt_oe(alt_oe), .alt_din(), .addfn(addfn));

	sxio_pad_model pads (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ext_en(ext_en),
		.ext_val(ext_val), .pad_in(pad_in));

	// compare one value and count it
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task results();
		if (expq.size() != 0)
			n_mismatch++;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one register request, set up on the falling edge
	task put(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		req = {1'b1, w, a, 4'hF, d};
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		put(1'b1, a, d);
	endtask

	// read request, expected answer noted for the watcher
	task rd(input logic [7:0] a, input logic [31:0] e);
		put(1'b0, a, 32'h0000_0000);
		expq.push_back(e);
	endtask

	task idle(input int n);
		repeat (n) begin
			@(negedge clk);
			req.sel = 1'b0;
		end
	endtask

	// watcher: every read answer against the oldest note
	always @(negedge clk) begin
		if (rvalid === 1'b1) begin
			if (expq.size() == 0)
				check(rdata, 32'hDEAD_BEEF);
			else
				check(rdata, expq.pop_front());
		end
	end

	// hang guard
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		results();
	end

	initial begin
		req = '0;
		addfn = '0;
		alt_dout = 16'h0000;
		alt_oe = 16'h0000;
		ext_en = 16'hFFFF;
		void'($urandom(87));
		ext_val = 16'($urandom);
		repeat (2) @(negedge clk);
		reset = 1'b0;
		// reset state of pins and registers
		check(pad_oe_n, 32'h0000_FFFF);
		check(pull_up_en, 32'h0000_2000);
		check(pull_dn_en, 32'h0000_4000);
		check(speed_sel, 32'h0C00_0000);
		check(pull_up_en_b, 32'h0000_0000);
		rd(8'h00, 32'h2800_0000);
		rd(8'h04, 32'h0000_0000);
		check(rdata_b, 32'h0000_0000);
		rd(8'h0C, 32'h2400_0000);
		rd(8'h08, 32'h0C00_0000);
		rd(8'h30, 32'h0000_0000); // unmapped
		rd(8'h18, 32'h0000_0000); // write-only
		r = $urandom;
		wr(8'h00, r);
		rd(8'h00, r);
		// pins 0-7 output, 8-11 input, 12-15 analog for converter use
		wr(8'h00, 32'hFF00_5555);
		wr(8'h04, 32'h0000_0000);
		wr(8'h0C, 32'h5539_0000);
		wr(8'h14, 32'h0000_00A5);
		idle(7);
		check(pad_out[7:0], 32'h0000_00A5);
		check(pad_oe_n, 32'h0000_FF00);
		check(rx_en, 32'h0000_0FFF);
		check(pull_up_en, 32'h0000_0100);
		check(pull_dn_en, 32'h0000_0200);
		rd(8'h10, {20'h0, ext_val[11:8], 8'hA5});
		// set word with a conflict, clear-only, back-to-back toggles
		wr(8'h18, 32'h0009_000A);
		wr(8'h28, 32'h0000_0080);
		wr(8'h2C, 32'h0000_0001);
		wr(8'h2C, 32'h0000_0001);
		check(pad_out[0], 32'h0000_0001);
		idle(1);
		check(pad_out[0], 32'h0000_0000);
		rd(8'h14, 32'h0000_002E);
		// open-drain on the output pins
		wr(8'h04, 32'h0000_00FF);
		idle(1);
		check(pad_oe_n[7:0], 32'h0000_002E);
		// pins 8-11 in alternate mode, open-drain
		alt_dout = 16'($urandom);
		alt_oe = 16'($urandom);
		r2 = $urandom;
		wr(8'h00, 32'hFFAA_5555);
		wr(8'h04, 32'h0000_0F00);
		wr(8'h24, r2);
		idle(6);
		dr = alt_oe[11:8] & ~alt_dout[11:8];
		check(pad_oe_n[11:8], {28'h0, ~dr});
		check(alt_din[11:8], {28'h0, ext_val[11:8] & ~dr});
		check(alt_sel[63:32], r2);
		rd(8'h24, r2);
		rd(8'h20, 32'h0000_0000);
		rd(8'h10, {20'h0, ext_val[11:8] & ~dr, 8'h2E});
		// alternate push-pull follows the peripheral
		wr(8'h04, 32'h0000_0000);
		idle(1);
		check(pad_out[11:8], {28'h0, alt_dout[11:8]});
		check(pad_oe_n[11:8], {28'h0, ~alt_oe[11:8]});
		// additional function takes over an analog pin, then lets go
		addfn = {16'h8000, 16'h8000, 16'h8000};
		idle(1);
		check({pad_out[15], pad_oe_n[15], rx_en[15]}, 32'h0000_0005);
		addfn = '0;
		idle(1);
		check({pad_oe_n[15], rx_en[15]}, 32'h0000_0002);
		// broken key order leaves pins free
		wr(8'h1C, 32'h0001_0002);
		wr(8'h1C, 32'h0000_0002);
		wr(8'h1C, 32'h0000_0002);
		wr(8'h00, 32'h0000_0000);
		rd(8'h00, 32'h0000_0000);
		// proper key freezes pin 0
		wr(8'h00, 32'h0000_0005);
		wr(8'h1C, 32'h0001_0001);
		wr(8'h1C, 32'h0000_0001);
		wr(8'h1C, 32'h0001_0001);
		wr(8'h00, 32'hFFFF_FFFF);
		wr(8'h04, 32'h0000_FFFF);
		rd(8'h00, 32'hFFFF_FFFD);
		rd(8'h04, 32'h0000_FFFE);
		rd(8'h1C, 32'h0001_0001);
		idle(2);
		// reset in mid-run clears the freeze
		reset = 1'b1;
		idle(2);
		reset = 1'b0;
		rd(8'h00, 32'h2800_0000);
		rd(8'h1C, 32'h0000_0000);
		idle(3);
		results();
	end
endmodule // tb

`default_nettype wire
